//--- design/ptc_camera.sv
// camera end: exposure-sync trigger generator for the projector
`timescale 1ns/1ps
module ptc_camera #(
  parameter int unsigned MAX_CYC = ptc_pkg::ALT_MAX_CYC,
  parameter int unsigned OFF_CYC = ptc_pkg::MIN_OFF_CYC,
  parameter int unsigned EVERY_CYC = ptc_pkg::EVERY_MAX_CYC
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // projector connector
  ptc_link_if.camera      link,
  // user side: exposure request
  input  wire logic [1:0] mode,
  input  wire logic       expose_start,
  input  wire logic [$clog2(MAX_CYC+1)-1:0] expose_cyc,
  input  wire logic       aux_out,
  // user side: status
  output logic            busy,
  output logic            projector_ok,
  output logic            robot_in
);
  initial begin
    if (MAX_CYC < 1 || OFF_CYC < 1 || EVERY_CYC < 1 || EVERY_CYC > MAX_CYC) begin
      $error("bad camera timing");
    end
  end

  localparam int unsigned CW = $clog2(MAX_CYC + OFF_CYC + 1);
  // limit fits the counter because it may not exceed MAX_CYC
  localparam logic [CW-1:0] EVERY_LIM = CW'(EVERY_CYC);

  logic          on_r;
  logic          cool_r;
  logic [CW-1:0] cnt_r;
  logic          alt_r;
  logic [1:0]    ok_s_r;
  logic [1:0]    rin_s_r;

  wire every_m = (mode == 2'(ptc_pkg::PTC_MODE_EVERY));
  wire alt_m   = (mode == 2'(ptc_pkg::PTC_MODE_ALTERNATE));
  wire high_m  = (mode == 2'(ptc_pkg::PTC_MODE_HIGH));
  // every-frame exposures are clipped so the projector cannot overheat
  wire [CW-1:0] req_len = (every_m && CW'(expose_cyc) > EVERY_LIM) ?
                          EVERY_LIM : CW'(expose_cyc);
  wire start_ok = expose_start && !on_r && !cool_r && (expose_cyc != '0);
  wire fire     = start_ok && (every_m || (alt_m && !alt_r));
  wire end_on   = on_r && (cnt_r <= CW'(1));
  wire end_cool = cool_r && (cnt_r <= CW'(1));

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      on_r   <= 1'b0;
      cool_r <= 1'b0;
      cnt_r  <= '0;
      alt_r  <= 1'b0;
    end else begin
      if (start_ok && alt_m) begin
        alt_r <= !alt_r;
      end
      if (fire) begin
        on_r  <= 1'b1;
        cnt_r <= req_len;
      end else if (end_on) begin
        on_r   <= 1'b0;
        cool_r <= 1'b1;
        cnt_r  <= CW'(OFF_CYC);
      end else if (end_cool) begin
        cool_r <= 1'b0;
        cnt_r  <= '0;
      end else if (on_r || cool_r) begin
        cnt_r <= cnt_r - CW'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      link.light_trigger <= 1'b0;
      link.cam_in2       <= 1'b0;
      busy               <= 1'b0;
      ok_s_r             <= 2'h0;
      rin_s_r            <= 2'h0;
      projector_ok       <= 1'b0;
      robot_in           <= 1'b0;
    end else begin
      link.light_trigger <= high_m || (fire || (on_r && !end_on));
      link.cam_in2       <= aux_out;
      busy               <= fire || (on_r && !end_on) || (cool_r && !end_cool) || end_on;
      ok_s_r             <= {ok_s_r[0], link.projector_ok};
      rin_s_r            <= {rin_s_r[0], link.cam_out1};
      projector_ok       <= ok_s_r[1];
      robot_in           <= rin_s_r[1];
    end
  end
endmodule : ptc_camera

//--- design/ptc_link_if.sv
// connector signals between camera side and projector
`timescale 1ns/1ps
interface ptc_link_if;
  logic light_trigger;
  logic cam_in2;
  logic projector_ok;
  logic cam_out1;

  modport projector (
    input  light_trigger,
    input  cam_in2,
    output projector_ok,
    output cam_out1
  );

  modport camera (
    output light_trigger,
    output cam_in2,
    input  projector_ok,
    input  cam_out1
  );
endinterface : ptc_link_if

//--- design/ptc_pkg.sv
// shared constants and types of the projector trigger control
package ptc_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int unsigned CLK_HZ            = 20_000_000;
  localparam int unsigned SHORT_PULSE_MS    = 25;
  localparam int unsigned SHORT_PULSE_CYC   = (CLK_HZ / 1000) * SHORT_PULSE_MS;
  localparam int unsigned MIN_OFF_MS        = 25;
  localparam int unsigned MIN_OFF_CYC       = (CLK_HZ / 1000) * MIN_OFF_MS;
  localparam int unsigned EVERY_MAX_MS      = 15;
  localparam int unsigned EVERY_MAX_CYC     = (CLK_HZ / 1000) * EVERY_MAX_MS;
  localparam int unsigned ALT_MAX_MS        = 18;
  localparam int unsigned ALT_MAX_CYC       = (CLK_HZ / 1000) * ALT_MAX_MS;

  // ************************************************************
  // analog figures, for reference only
  // ************************************************************
  localparam int unsigned FULL_CURRENT_MA   = 2200;
  localparam int unsigned REDUCED_CURRENT_MA = 400;
  localparam int unsigned REDUCED_PERCENT   = 18;
  localparam int unsigned OVERTEMP_DEG_C    = 75;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic        RST_LEVEL         = 1'b0;
  localparam logic [2:0]  RST_COLOUR        = 3'h0;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    PTC_IDLE    = 2'h0,
    PTC_FULL    = 2'h1,
    PTC_REDUCED = 2'h3
  } ptc_drive_e;

  typedef enum logic [1:0] {
    PTC_MODE_OFF       = 2'h0,
    PTC_MODE_EVERY     = 2'h1,
    PTC_MODE_ALTERNATE = 2'h3,
    PTC_MODE_HIGH      = 2'h2
  } ptc_mode_e;

  // status colour one-hot: bit 2 red, bit 1 blue, bit 0 green
  localparam logic [2:0]  COLOUR_RED        = 3'h4;
  localparam logic [2:0]  COLOUR_BLUE       = 3'h2;
  localparam logic [2:0]  COLOUR_GREEN      = 3'h1;

endpackage : ptc_pkg

//--- design/ptc_projector.sv
// projector end: light drive, status output and indicator, gpio mirrors
`timescale 1ns/1ps
module ptc_projector #(
  parameter int unsigned SHORT_CYC = ptc_pkg::SHORT_PULSE_CYC
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // camera-side connector
  ptc_link_if.projector   link,
  // robot-side connector
  input  wire logic       robot_in1,
  output logic            robot_exposure,
  output logic            robot_out2,
  // temperature sensor comparator, high above threshold
  input  wire logic       overtemp_in,
  // light source drive
  output logic            led_on,
  output logic            led_full,
  output logic            led_reduced,
  // status indicator, one-hot
  output logic [2:0]      colour
);
  // ************************************************************
  // parameter checks
  // ************************************************************
  initial begin
    if (SHORT_CYC < 2) $error("SHORT_CYC too small");
  end

  localparam int unsigned CW = $clog2(SHORT_CYC + 1);

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic trig_s;
  logic in2_s;
  logic rin1_s;
  logic hot_s;

  // filter swallows single-cycle glitches at the cost of one more cycle
  ptc_sync u_trig (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .async_in (link.light_trigger),
    .sync_out (trig_s)
  );

  ptc_sync u_in2 (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .async_in (link.cam_in2),
    .sync_out (in2_s)
  );

  ptc_sync u_rin1 (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .async_in (robot_in1),
    .sync_out (rin1_s)
  );

  ptc_sync u_hot (
    .sys_clk  (sys_clk),
    .reset_n  (reset_n),
    .async_in (overtemp_in),
    .sync_out (hot_s)
  );

  // ************************************************************
  // pulse timing
  // ************************************************************
  ptc_pkg::ptc_drive_e state_r;
  ptc_pkg::ptc_drive_e state_nxt;
  logic [CW-1:0]       cnt_r;
  logic [CW-1:0]       cnt_nxt;

  // counter saturates so an over-long pulse never wraps back to full
  wire limit_hit = (cnt_r >= CW'(SHORT_CYC - 1));

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    unique case (state_r)
      ptc_pkg::PTC_IDLE: begin
        cnt_nxt = '0;
        if (trig_s) begin
          state_nxt = ptc_pkg::PTC_FULL;
        end
      end
      ptc_pkg::PTC_FULL: begin
        if (!trig_s) begin
          state_nxt = ptc_pkg::PTC_IDLE;
        end else if (limit_hit) begin
          state_nxt = ptc_pkg::PTC_REDUCED;
        end else begin
          cnt_nxt = cnt_r + CW'(1);
        end
      end
      ptc_pkg::PTC_REDUCED: begin
        if (!trig_s) begin
          state_nxt = ptc_pkg::PTC_IDLE;
        end
      end
      default: begin
        state_nxt = ptc_pkg::PTC_IDLE;
      end
    endcase
  end

  wire lit_nxt     = (state_nxt != ptc_pkg::PTC_IDLE);
  wire full_nxt    = (state_nxt == ptc_pkg::PTC_FULL);
  wire reduced_nxt = (state_nxt == ptc_pkg::PTC_REDUCED);

  // red wins, then blue, then green
  function automatic logic [2:0] colour_of(input logic hot, input logic lit);
    if (hot) begin
      return ptc_pkg::COLOUR_RED;
    end else if (lit) begin
      return ptc_pkg::COLOUR_BLUE;
    end
    return ptc_pkg::COLOUR_GREEN;
  endfunction : colour_of

  wire [2:0] colour_nxt = colour_of(hot_s, lit_nxt);

  // ************************************************************
  // status and mirror next values
  // ************************************************************
  // present output follows the filtered temperature, not the raw pin
  wire ok_nxt       = !hot_s;
  wire cam_out1_nxt = rin1_s;
  wire expo_nxt     = trig_s;
  wire out2_nxt     = in2_s;

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ptc_pkg::PTC_IDLE;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // ************************************************************
  // light drive
  // ************************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      led_on      <= ptc_pkg::RST_LEVEL;
      led_full    <= ptc_pkg::RST_LEVEL;
      led_reduced <= ptc_pkg::RST_LEVEL;
    end else begin
      led_on      <= lit_nxt;
      led_full    <= full_nxt;
      led_reduced <= reduced_nxt;
    end
  end

  // ************************************************************
  // status indicator and present output
  // ************************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      colour            <= ptc_pkg::RST_COLOUR;
      link.projector_ok <= ptc_pkg::RST_LEVEL;
    end else begin
      colour            <= colour_nxt;
      link.projector_ok <= ok_nxt;
    end
  end

  // ************************************************************
  // gpio mirrors
  // ************************************************************
  // plain level copies; each shares the trigger's filter latency
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      link.cam_out1  <= ptc_pkg::RST_LEVEL;
      robot_exposure <= ptc_pkg::RST_LEVEL;
      robot_out2     <= ptc_pkg::RST_LEVEL;
    end else begin
      link.cam_out1  <= cam_out1_nxt;
      robot_exposure <= expo_nxt;
      robot_out2     <= out2_nxt;
    end
  end
endmodule : ptc_projector

//--- design/ptc_sync.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module ptc_sync (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic reset_n,
  // data
  input  wire logic async_in,
  output logic      sync_out
);
  logic [2:0] stage_r;

  // only stages 1 and 2 are compared; stage 0 feeds stage 1 alone
  wire agree = (stage_r[1] == stage_r[2]);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage_r  <= 3'h0;
      sync_out <= ptc_pkg::RST_LEVEL;
    end else begin
      stage_r  <= {stage_r[1:0], async_in};
      if (agree) begin
        sync_out <= stage_r[2];
      end
    end
  end
endmodule : ptc_sync

//--- sim/ptc_link_asserts.sv
// concurrent checks on the camera-to-projector link
`timescale 1ns/1ps
module ptc_link_asserts #(
  parameter int unsigned SHORT_CYC = 20,
  parameter int unsigned MAX_CYC   = 40,
  parameter int unsigned OFF_CYC   = 20
) (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       reset_n,
  // link and user pins
  input wire logic       light_trigger,
  input wire logic       cam_in2,
  input wire logic       projector_ok,
  input wire logic       cam_out1,
  input wire logic [1:0] mode,
  input wire logic       robot_in1,
  input wire logic       overtemp_in,
  // projector outputs
  input wire logic       robot_exposure,
  input wire logic       robot_out2,
  input wire logic       led_on,
  input wire logic       led_full,
  input wire logic       led_reduced,
  input wire logic [2:0] colour
);
  logic [31:0] up_r;
  logic [31:0] on_r;
  logic [31:0] hi_r;
  logic [31:0] off_r;
  logic        ready;
  // off count starts full: a first pulse after reset is legal
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      up_r  <= 32'h0;
      on_r  <= 32'h0;
      hi_r  <= 32'h0;
      off_r <= OFF_CYC;
    end else begin
      up_r  <= (up_r == 32'hf) ? up_r : up_r + 32'h1;
      on_r  <= led_on ? on_r + 32'h1 : 32'h0;
      hi_r  <= light_trigger ? hi_r + 32'h1 : 32'h0;
      off_r <= light_trigger ? 32'h0 : off_r + 32'h1;
    end
  end
  // $past needs a full sync pipeline of history after reset
  assign ready = (up_r == 32'hf);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_pin_rise; $rose(light_trigger); endsequence
  sequence s_lit_full; led_on && led_full && !led_reduced; endsequence
  a_rise_lights: assert property (ready ##0 s_pin_rise |-> ##5 s_lit_full)
    else $error("light not lit at full power after trigger rise");
  a_light_follows: assert property (ready |-> led_on == $past(light_trigger, 5))
    else $error("light does not follow trigger");
  a_dark_undriven: assert property (!led_on |-> !led_full && !led_reduced)
    else $error("drive active while light off");
  a_full_early: assert property (led_on && on_r < SHORT_CYC |-> led_full && !led_reduced)
    else $error("not at full current inside short limit");
  a_reduced_late: assert property (led_on && on_r >= SHORT_CYC |-> led_reduced && !led_full)
    else $error("not reduced after short limit");
  a_off_gap: assert property (s_pin_rise |-> off_r >= OFF_CYC)
    else $error("trigger off time too short");
  a_pulse_bound: assert property (light_trigger && hi_r >= MAX_CYC |-> mode == 2'h2 || $past(mode) == 2'h2)
    else $error("trigger pulse too long");
  a_ok_temp: assert property (ready |-> projector_ok == !$past(overtemp_in, 5))
    else $error("present output wrong for temperature");
  a_red_hot: assert property (ready && $past(overtemp_in, 5) |-> colour == ptc_pkg::COLOUR_RED)
    else $error("indicator not red when hot");
  a_blue_green: assert property (ready && !$past(overtemp_in, 5) |->
    colour == (led_on ? ptc_pkg::COLOUR_BLUE : ptc_pkg::COLOUR_GREEN))
    else $error("indicator not blue or green as expected");
  a_mirror_out: assert property (ready |-> robot_exposure == $past(light_trigger, 5)
    && robot_out2 == $past(cam_in2, 5))
    else $error("robot mirror outputs wrong");
  a_mirror_in: assert property (ready |-> cam_out1 == $past(robot_in1, 5))
    else $error("camera mirror output wrong");
endmodule : ptc_link_asserts

//--- sim/tb.sv
// self-checking bench joining camera and projector ends
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (got), (exp)); end end
module tb;
  // ************************************************************
  // setup
  // ************************************************************
  localparam int unsigned SHORT = 20;
  localparam int unsigned MAXC  = 40;
  localparam int unsigned EVERYC = 30;
  localparam int unsigned OFFC  = 20;
  localparam int unsigned LW    = $clog2(MAXC + 1);
  logic          sys_clk = 1'b0;
  logic          reset_n = 1'b0;
  logic [1:0]    mode = 2'h0;
  logic          expose_start = 1'b0;
  logic [LW-1:0] expose_cyc = '0;
  logic          aux_out = 1'b0;
  logic          robot_in1 = 1'b0;
  logic          overtemp_in = 1'b0;
  logic          busy, projector_ok, robot_in, robot_exposure, robot_out2;
  logic          led_on, led_full, led_reduced;
  logic [2:0]    colour;
  logic [31:0]   pulses[$];
  logic [1:0]    status[$];
  logic [31:0]   p_exp;
  logic [1:0]    s_exp;
  logic [15:0]   on_len = 16'h0;
  logic [15:0]   full_len = 16'h0;
  logic [1:0]    st_last = 2'h0;
  int            errors = 0;
  int            n_compared = 0;
  int            lens[5] = '{3, 19, 20, 21, 40};
  int unsigned   rnd;
  always #25 sys_clk = ~sys_clk;
  ptc_link_if ptc_link_if_i ();
  ptc_projector #(.SHORT_CYC(SHORT)) ptc_projector_i (.sys_clk(sys_clk), .reset_n(reset_n),
    .link(ptc_link_if_i), .robot_in1(robot_in1), .robot_exposure(robot_exposure),
    .robot_out2(robot_out2), .overtemp_in(overtemp_in), .led_on(led_on),
    .led_full(led_full), .led_reduced(led_reduced), .colour(colour));
  ptc_camera #(.MAX_CYC(MAXC), .OFF_CYC(OFFC), .EVERY_CYC(EVERYC)) ptc_camera_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .link(ptc_link_if_i), .mode(mode),
    .expose_start(expose_start),
    .expose_cyc(expose_cyc), .aux_out(aux_out), .busy(busy), .projector_ok(projector_ok),
    .robot_in(robot_in));
  ptc_link_asserts #(.SHORT_CYC(SHORT), .MAX_CYC(MAXC), .OFF_CYC(OFFC)) ptc_link_asserts_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .light_trigger(ptc_link_if_i.light_trigger),
    .cam_in2(ptc_link_if_i.cam_in2), .projector_ok(ptc_link_if_i.projector_ok),
    .cam_out1(ptc_link_if_i.cam_out1), .mode(mode), .robot_in1(robot_in1),
    .overtemp_in(overtemp_in), .robot_exposure(robot_exposure), .robot_out2(robot_out2),
    .led_on(led_on), .led_full(led_full), .led_reduced(led_reduced), .colour(colour));
  // ************************************************************
  // drivers
  // ************************************************************
  task automatic expose(input logic [1:0] md, input int len, input bit fires);
    int n;
    int el;
    n = 0;
    while (busy !== 1'b0 && n < 200) begin
      @(posedge sys_clk);
      #2;
      n++;
    end
    if (n >= 200) errors++;
    // every-frame exposures are capped at the every-frame limit EVERYC
    el = (md == 2'h1 && len > int'(EVERYC)) ? int'(EVERYC) : len;
    mode = md;
    expose_cyc = LW'(len);
    aux_out = 1'($urandom);
    expose_start = 1'b1;
    if (fires) pulses.push_back({16'(el), 16'((el < SHORT) ? el : SHORT)});
    @(posedge sys_clk);
    #2;
    expose_start = 1'b0;
    repeat (3) @(posedge sys_clk);
    #2;
  endtask : expose
  task automatic set_status(input logic ot, input logic ri);
    overtemp_in = ot;
    robot_in1 = ri;
    status.push_back({~ot, ri});
    repeat (12) @(posedge sys_clk);
    #2;
  endtask : set_status
  task automatic end_of_test();
    if (errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  // ************************************************************
  // monitors
  // ************************************************************
  // outputs are looked at mid-cycle, where they have settled
  always @(negedge sys_clk) begin
    if (led_on === 1'b1) begin
      on_len = on_len + 16'h1;
      if (led_full === 1'b1) full_len = full_len + 16'h1;
    end else if (on_len != 16'h0) begin
      p_exp = (pulses.size() > 0) ? pulses.pop_front() : 32'hx;
      `CHK({on_len, full_len}, p_exp)
      on_len = 16'h0;
      full_len = 16'h0;
    end
    if (reset_n === 1'b1 && {projector_ok, robot_in} !== st_last) begin
      st_last = {projector_ok, robot_in};
      s_exp = (status.size() > 0) ? status.pop_front() : 2'hx;
      `CHK(st_last, s_exp)
    end
  end
  // ************************************************************
  // sequence
  // ************************************************************
  initial begin
    #1000000;
    errors++;
    end_of_test();
  end
  initial begin
    rnd = $urandom(78);
    repeat (4) @(posedge sys_clk);
    #2;
    reset_n = 1'b1;
    status.push_back(2'h2);
    repeat (10) @(posedge sys_clk);
    #2;
    // alternate mode lights only every second start
    for (int i = 0; i < 4; i++) expose(2'h3, 12 + i, (i % 2) == 0);
    foreach (lens[i]) expose(2'h1, lens[i], 1'b1);
    for (int i = 0; i < 6; i++) expose(2'h1, 3 + int'($urandom % 38), 1'b1);
    expose(2'h1, 10, 1'b1);
    // a start while busy must be dropped
    expose_start = 1'b1;
    @(posedge sys_clk);
    #2;
    expose_start = 1'b0;
    expose(2'h1, 0, 1'b0);
    set_status(1'b0, 1'b1);
    set_status(1'b1, 1'b1);
    set_status(1'b0, 1'b1);
    set_status(1'b0, 1'b0);
    // steady light, overheating midway
    expose(2'h0, 1, 1'b0);
    mode = 2'h2;
    pulses.push_back({16'd60, 16'(SHORT)});
    repeat (20) @(posedge sys_clk);
    #2;
    set_status(1'b1, 1'b0);
    repeat (28) @(posedge sys_clk);
    #2;
    mode = 2'h0;
    set_status(1'b0, 1'b0);
    repeat (60) @(posedge sys_clk);
    #2;
    `CHK(32'(pulses.size() + status.size()), 32'h0)
    end_of_test();
  end
endmodule : tb
